// [src/baro_regs_pkg.sv]
/*
 * constants for the pressure sensor output and status register block:
 * register offsets, field positions, reset values and widths.
 * assumes an 8-bit register address space reached by a byte-wide register port.
 */
package baro_regs_pkg;
    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_PRESSURE_OFFSET_LOW    = 8'h18;
    localparam logic [7:0] OFS_PRESSURE_OFFSET_HIGH   = 8'h19;
    localparam logic [7:0] OFS_LOW_POWER_CONFIG       = 8'h1A;
    localparam logic [7:0] OFS_SAMPLE_STATUS          = 8'h27;
    localparam logic [7:0] OFS_PRESSURE_RESULT_LOW    = 8'h28;
    localparam logic [7:0] OFS_PRESSURE_RESULT_MID    = 8'h29;
    localparam logic [7:0] OFS_PRESSURE_RESULT_HIGH   = 8'h2A;
    localparam logic [7:0] OFS_TEMPERATURE_RESULT_LOW = 8'h2B;
    localparam logic [7:0] OFS_TEMPERATURE_RESULT_HIGH = 8'h2C;
    localparam logic [7:0] OFS_FILTER_STATE_CLEAR     = 8'h33;
    // ==========================================================
    // field positions
    localparam int LOW_CURRENT_SELECT_BIT = 0;
    localparam int LOW_POWER_RESERVED_BIT = 1;
    localparam int PRESSURE_FRESH_BIT     = 0;
    localparam int TEMPERATURE_FRESH_BIT  = 1;
    localparam int PRESSURE_OVERRUN_BIT   = 4;
    localparam int TEMPERATURE_OVERRUN_BIT = 5;
    // ==========================================================
    // reset values and widths
    localparam logic [7:0] LOW_POWER_CONFIG_RESET = 8'h00;
    localparam logic [7:0] PRESSURE_OFFSET_RESET  = 8'h00;
    localparam int PRESSURE_WIDTH    = 24;
    localparam int TEMPERATURE_WIDTH = 16;
    localparam int OFFSET_WIDTH      = 16;
    localparam int OFFSET_SHIFT      = 8;
    localparam int SAMPLE_RATE_WIDTH = 3;
    localparam logic [2:0] SAMPLE_RATE_POWER_DOWN = 3'h0;
endpackage : baro_regs_pkg

// [src/baro_offset_sub.sv]
/*
 * offset correction for the raw pressure measurement.
 * assumes raw and offset are two's-complement and stable when sampled.
 */
`timescale 1ns/10ps
module baro_offset_sub
    import baro_regs_pkg::*;
#(
    parameter int PW = baro_regs_pkg::PRESSURE_WIDTH,
    parameter int OW = baro_regs_pkg::OFFSET_WIDTH
) (
    input  wire logic [PW-1:0] raw_pressure,
    input  wire logic [OW-1:0] offset_value,
    output logic      [PW-1:0] corrected
);
    logic [PW-1:0] scaled;
    // ==========================================================
    // sign-extend offset, scale by 256, subtract; wraps like the hardware counter
    always_comb begin
        scaled    = {{(PW-OW-OFFSET_SHIFT){offset_value[OW-1]}}, offset_value, {OFFSET_SHIFT{1'b0}}};
        corrected = raw_pressure - scaled;
    end
endmodule : baro_offset_sub

// [src/baro_sensor_output_status_regs.sv]
/*
 * output and status registers of the barometric sensor, reached over a
 * byte-wide register port behind the serial host interface.
 * assumes the sampling front end delivers one-cycle result strobes on sys_clk
 * (the internal sampling tick domain) and that the serial slave presents
 * one-cycle read and write strobes with a stable address.
 */
// Overview of operation
// - bit 0 of low power config picks low-current mode, reset 0
// - status bit 5 sets when unread temperature is overwritten
// - status bit 4 sets when unread pressure is overwritten
// - status bit 1 shows a fresh temperature result
// - status bit 0 shows a fresh pressure result
// - status flags refresh once per sampling period
// - pressure is 24-bit two's complement, low byte at lowest address
// - pressure result is measurement minus stored offset times 256
// - temperature is 16-bit two's complement, low byte at lower address
// - reading filter clear register resets low-pass filter state
// - middle pressure byte holds result bits 15 to 8
// - with block update hold, results freeze until high pressure byte read
// - rate setting zero means power-down, results kept, port reachable
// - subtract offset times 256 before storing pressure
// - single-shot completion loads results, flags, clears trigger
`timescale 1ns/10ps
module baro_sensor_output_status_regs
    import baro_regs_pkg::*;
#(
    parameter int PW = baro_regs_pkg::PRESSURE_WIDTH,
    parameter int TW = baro_regs_pkg::TEMPERATURE_WIDTH
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic [7:0]            reg_addr,
    input  wire logic                  reg_read,
    input  wire logic                  reg_write,
    input  wire logic [7:0]            reg_wdata,
    output logic      [7:0]            reg_rdata,
    input  wire logic [baro_regs_pkg::SAMPLE_RATE_WIDTH-1:0] sample_rate_setting,
    input  wire logic                  block_update_hold,
    input  wire logic                  one_shot_trigger,
    input  wire logic                  sample_done,
    input  wire logic [PW-1:0]         raw_pressure,
    input  wire logic [TW-1:0]         raw_temperature,
    output logic                       one_shot_clear,
    output logic                       low_current_select,
    output logic                       filter_clear
);
    import baro_regs_pkg::*;

    // ==========================================================
    // state
    typedef enum logic [2:0] {
        ACQ_IDLE    = 3'b001,
        ACQ_ONESHOT = 3'b010,
        ACQ_CONT    = 3'b100
    } acq_e;

    acq_e                     acq;
    acq_e                     next_acq;
    logic [7:0]               low_power_config;
    logic [7:0]               next_low_power_config;
    logic [15:0]              pressure_offset_value;
    logic [15:0]              next_pressure_offset_value;
    logic [PW-1:0]            pressure_result_bits;
    logic [PW-1:0]            next_pressure_result_bits;
    logic [TW-1:0]            temperature_result_bits;
    logic [TW-1:0]            next_temperature_result_bits;
    logic                     pressure_fresh_flag;
    logic                     next_pressure_fresh_flag;
    logic                     temperature_fresh_flag;
    logic                     next_temperature_fresh_flag;
    logic                     pressure_overrun;
    logic                     next_pressure_overrun;
    logic                     temperature_overrun;
    logic                     next_temperature_overrun;
    logic                     hold_active;
    logic                     next_hold_active;
    logic [7:0]               next_reg_rdata;
    logic                     next_one_shot_clear;
    logic                     next_filter_clear;
    logic [PW-1:0]            corrected_pressure;
    logic                     load;
    logic                     press_read;
    logic                     temp_read;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // result byte decode, shared by the flag clears and the update hold
    function automatic logic is_pressure_byte(input logic [7:0] a);
        case (a)
            OFS_PRESSURE_RESULT_LOW,
            OFS_PRESSURE_RESULT_MID,
            OFS_PRESSURE_RESULT_HIGH: is_pressure_byte = 1'b1;
            default:                  is_pressure_byte = 1'b0;
        endcase
    endfunction : is_pressure_byte

    function automatic logic is_temperature_byte(input logic [7:0] a);
        case (a)
            OFS_TEMPERATURE_RESULT_LOW,
            OFS_TEMPERATURE_RESULT_HIGH: is_temperature_byte = 1'b1;
            default:                     is_temperature_byte = 1'b0;
        endcase
    endfunction : is_temperature_byte

    // status layout; unused bits read zero
    function automatic logic [7:0] status_byte(input logic p_fresh, input logic t_fresh,
                                               input logic p_over, input logic t_over);
        status_byte                          = 8'h00;
        status_byte[PRESSURE_FRESH_BIT]      = p_fresh;
        status_byte[TEMPERATURE_FRESH_BIT]   = t_fresh;
        status_byte[PRESSURE_OVERRUN_BIT]    = p_over;
        status_byte[TEMPERATURE_OVERRUN_BIT] = t_over;
    endfunction : status_byte

    baro_offset_sub #(
        .PW (PW),
        .OW (OFFSET_WIDTH)
    ) u_offset (
        .raw_pressure (raw_pressure),
        .offset_value (pressure_offset_value),
        .corrected    (corrected_pressure)
    );

    // ==========================================================
    // acquisition sequencing
    always_comb begin
        next_acq            = acq;
        next_one_shot_clear = 1'b0;
        case (acq)
            ACQ_IDLE: begin
                if (sample_rate_setting != SAMPLE_RATE_POWER_DOWN) begin
                    next_acq = ACQ_CONT;
                end else if (one_shot_trigger && !one_shot_clear) begin
                    next_acq = ACQ_ONESHOT;
                end
            end
            ACQ_ONESHOT: begin
                if (sample_done) begin
                    next_acq            = ACQ_IDLE;
                    next_one_shot_clear = 1'b1;
                end
            end
            ACQ_CONT: begin
                // power-down stops loading but keeps the last sample
                if (sample_rate_setting == SAMPLE_RATE_POWER_DOWN) begin
                    next_acq = ACQ_IDLE;
                end
            end
            default: next_acq = ACQ_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            acq            <= ACQ_IDLE;
            one_shot_clear <= 1'b0;
        end else begin
            acq            <= next_acq;
            one_shot_clear <= next_one_shot_clear;
        end
    end

    // ==========================================================
    // block update hold
    assign press_read = reg_read && is_pressure_byte(reg_addr);
    assign temp_read  = reg_read && is_temperature_byte(reg_addr);

    always_comb begin
        next_hold_active = hold_active;
        // the top pressure byte closes a frozen read even when it is the only byte read
        if (!block_update_hold || (reg_read && hit(reg_addr, OFS_PRESSURE_RESULT_HIGH))) begin
            next_hold_active = 1'b0;
        end else if (press_read || temp_read) begin
            next_hold_active = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hold_active <= 1'b0;
        end else begin
            hold_active <= next_hold_active;
        end
    end

    // ==========================================================
    // results and status
    always_comb begin
        // a sample arriving in ACQ_IDLE is dropped; held results stay put
        // the hold also covers the cycle of the first byte read, else later bytes would mix two samples
        load = sample_done && (acq != ACQ_IDLE) && !hold_active && !next_hold_active;

        next_pressure_result_bits    = pressure_result_bits;
        next_temperature_result_bits = temperature_result_bits;
        next_pressure_fresh_flag     = pressure_fresh_flag;
        next_temperature_fresh_flag  = temperature_fresh_flag;
        next_pressure_overrun        = pressure_overrun;
        next_temperature_overrun     = temperature_overrun;
        // read clears first so a same-cycle new sample wins
        if (press_read) begin
            next_pressure_fresh_flag = 1'b0;
            next_pressure_overrun    = 1'b0;
        end
        if (temp_read) begin
            next_temperature_fresh_flag = 1'b0;
            next_temperature_overrun    = 1'b0;
        end
        if (load) begin
            next_pressure_result_bits    = corrected_pressure;
            next_temperature_result_bits = raw_temperature;
            next_pressure_overrun        = pressure_fresh_flag;
            next_temperature_overrun     = temperature_fresh_flag;
            next_pressure_fresh_flag     = 1'b1;
            next_temperature_fresh_flag  = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pressure_result_bits    <= '0;
            temperature_result_bits <= '0;
            pressure_fresh_flag     <= 1'b0;
            temperature_fresh_flag  <= 1'b0;
            pressure_overrun        <= 1'b0;
            temperature_overrun     <= 1'b0;
        end else begin
            pressure_result_bits    <= next_pressure_result_bits;
            temperature_result_bits <= next_temperature_result_bits;
            pressure_fresh_flag     <= next_pressure_fresh_flag;
            temperature_fresh_flag  <= next_temperature_fresh_flag;
            pressure_overrun        <= next_pressure_overrun;
            temperature_overrun     <= next_temperature_overrun;
        end
    end

    // ==========================================================
    // register port
    always_comb begin
        next_low_power_config      = low_power_config;
        next_pressure_offset_value = pressure_offset_value;
        // host keeps bits 7..2 zero and bit 1 unchanged; stored as written
        if (reg_write && hit(reg_addr, OFS_LOW_POWER_CONFIG)) begin
            next_low_power_config = reg_wdata;
        end
        if (reg_write && hit(reg_addr, OFS_PRESSURE_OFFSET_LOW)) begin
            next_pressure_offset_value[7:0] = reg_wdata;
        end
        if (reg_write && hit(reg_addr, OFS_PRESSURE_OFFSET_HIGH)) begin
            next_pressure_offset_value[15:8] = reg_wdata;
        end

        next_filter_clear = reg_read && hit(reg_addr, OFS_FILTER_STATE_CLEAR);

        next_reg_rdata = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                OFS_LOW_POWER_CONFIG:        next_reg_rdata = low_power_config;
                OFS_PRESSURE_OFFSET_LOW:     next_reg_rdata = pressure_offset_value[7:0];
                OFS_PRESSURE_OFFSET_HIGH:    next_reg_rdata = pressure_offset_value[15:8];
                OFS_SAMPLE_STATUS:           next_reg_rdata = status_byte(pressure_fresh_flag, temperature_fresh_flag,
                                                                          pressure_overrun, temperature_overrun);
                OFS_PRESSURE_RESULT_LOW:     next_reg_rdata = pressure_result_bits[7:0];
                OFS_PRESSURE_RESULT_MID:     next_reg_rdata = pressure_result_bits[15:8];
                OFS_PRESSURE_RESULT_HIGH:    next_reg_rdata = pressure_result_bits[23:16];
                OFS_TEMPERATURE_RESULT_LOW:  next_reg_rdata = temperature_result_bits[7:0];
                OFS_TEMPERATURE_RESULT_HIGH: next_reg_rdata = temperature_result_bits[15:8];
                default:                     next_reg_rdata = 8'h00;
            endcase
        end else begin
            next_reg_rdata = reg_rdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            low_power_config      <= LOW_POWER_CONFIG_RESET;
            pressure_offset_value <= {PRESSURE_OFFSET_RESET, PRESSURE_OFFSET_RESET};
            reg_rdata             <= 8'h00;
            filter_clear          <= 1'b0;
            low_current_select    <= 1'b0;
        end else begin
            low_power_config      <= next_low_power_config;
            pressure_offset_value <= next_pressure_offset_value;
            reg_rdata             <= next_reg_rdata;
            filter_clear          <= next_filter_clear;
            low_current_select    <= next_low_power_config[LOW_CURRENT_SELECT_BIT];
        end
    end

endmodule : baro_sensor_output_status_regs

// [tb/baro_host_model.sv]
/* register host model: drives the byte-wide register port as the serial slave would.
 * assumes strobes are sampled on the rising sys_clk edge and held one cycle. */
`timescale 1ns/10ps
module baro_host_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic            reg_read,
    output logic            reg_write,
    output logic      [7:0] reg_wdata
);
    initial begin
        reg_addr  = 8'h00;
        reg_read  = 1'b0;
        reg_write = 1'b0;
        reg_wdata = 8'h00;
    end
    // ==========================================================
    // transfers: released lines show the inverse, so a stale copy never passes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_write = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_addr = a;
        reg_read = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_read = 1'b0;
        reg_addr = ~a;
        d        = reg_rdata;
    endtask : rd
endmodule : baro_host_model

// [tb/baro_regs_sva.sv]
/* port checker for the sensor output and status register block.
 * assumes one clock, sys_clk, and rstn asynchronous active low. */
`timescale 1ns/10ps
module baro_regs_sva
    import baro_regs_pkg::*;
(
    input wire logic                         sys_clk,
    input wire logic                         rstn,
    input wire logic [7:0]                   reg_addr,
    input wire logic                         reg_read,
    input wire logic                         reg_write,
    input wire logic [7:0]                   reg_wdata,
    input wire logic [7:0]                   reg_rdata,
    input wire logic [SAMPLE_RATE_WIDTH-1:0] sample_rate_setting,
    input wire logic                         block_update_hold,
    input wire logic                         one_shot_trigger,
    input wire logic                         sample_done,
    input wire logic                         one_shot_clear,
    input wire logic                         low_current_select,
    input wire logic                         filter_clear
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // sequences: first cycle of continuous mode drops its sample, so it is excluded
    sequence s_load;
        sample_done && !block_update_hold && sample_rate_setting != 3'h0 && $past(sample_rate_setting) != 3'h0;
    endsequence
    sequence s_status_read;
        reg_read && reg_addr == OFS_SAMPLE_STATUS;
    endsequence
    // ==========================================================
    // assertions
    a_fresh_flags_set: assert property (s_load ##1 !reg_read ##1 s_status_read |=> reg_rdata[1:0] == 2'b11)
        else $error("fresh flags missing after a load");
    a_overrun_flags_set: assert property (s_load ##2 s_load ##2 s_status_read |=> reg_rdata[5:4] == 2'b11)
        else $error("overrun flags missing after two loads");
    a_filter_pulse: assert property (reg_read && reg_addr == OFS_FILTER_STATE_CLEAR |=> filter_clear)
        else $error("filter clear pulse missing");
    a_filter_cause: assert property (filter_clear |-> $past(reg_read) && $past(reg_addr) == OFS_FILTER_STATE_CLEAR)
        else $error("filter clear without a read");
    a_low_current_write: assert property (reg_write && reg_addr == OFS_LOW_POWER_CONFIG |=> low_current_select == $past(reg_wdata[0]))
        else $error("low current select not written");
    a_low_current_keep: assert property (!(reg_write && reg_addr == OFS_LOW_POWER_CONFIG) |=> $stable(low_current_select))
        else $error("low current select changed without write");
    a_shot_done: assert property (sample_rate_setting == 3'h0 && one_shot_trigger && $past(one_shot_trigger)
        && sample_done && !block_update_hold |=> one_shot_clear)
        else $error("single shot completion not signalled");
    a_shot_cause: assert property (one_shot_clear |-> $past(sample_done))
        else $error("trigger clear without a sample");
    a_shot_single: assert property (one_shot_clear |=> !one_shot_clear)
        else $error("trigger clear longer than one cycle");
endmodule : baro_regs_sva

bind baro_sensor_output_status_regs baro_regs_sva i_baro_regs_sva (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_read(reg_read), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_rate_setting(sample_rate_setting),
    .block_update_hold(block_update_hold), .one_shot_trigger(one_shot_trigger), .sample_done(sample_done),
    .one_shot_clear(one_shot_clear), .low_current_select(low_current_select), .filter_clear(filter_clear)
);

// [tb/baro_sensor_output_status_regs_bench.sv]
/* self-checking bench for the sensor output and status registers.
 * assumes the host model drives the register port; the bench drives samples. */
`timescale 1ns/10ps
module baro_sensor_output_status_regs_bench;
    import baro_regs_pkg::*;
    logic        sys_clk, rstn, reg_read, reg_write, hold, trig, sdone, osc, lcs, fclr, rd_seen, fc_exp;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, last_rd;
    logic [2:0]  rate;
    logic [23:0] rawp, p, pa, pb;
    logic [15:0] rawt, t, ta, tb, off;
    logic [31:0] seed, x;
    logic [8:0]  notes[$];
    logic [8:0]  note;
    int          err_total, cmp_count;
    baro_host_model i_baro_host_model (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata));
    baro_sensor_output_status_regs i_baro_sensor_output_status_regs (.sys_clk(sys_clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .sample_rate_setting(rate), .block_update_hold(hold), .one_shot_trigger(trig),
        .sample_done(sdone), .raw_pressure(rawp), .raw_temperature(rawt), .one_shot_clear(osc),
        .low_current_select(lcs), .filter_clear(fclr));
    always #2 sys_clk = ~sys_clk;
    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_byte
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic report_and_stop();
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic c);
        notes.push_back({c, e});
        i_baro_host_model.rd(a, last_rd);
    endtask : rd
    task automatic sample(output logic [23:0] sp, output logic [15:0] st);
        x = rnd();
        sp = x[23:0];
        x = rnd();
        st = x[15:0];
        @(posedge sys_clk);
        #1;
        rawp  = sp;
        rawt  = st;
        sdone = 1'b1;
        @(posedge sys_clk);
        #1;
        sdone = 1'b0;
        rawp  = ~sp;
        rawt  = ~st;
    endtask : sample
    task automatic rd_all(input logic [23:0] ep, input logic [15:0] et);
        rd(OFS_PRESSURE_RESULT_LOW, ep[7:0], 1'b1);
        rd(OFS_PRESSURE_RESULT_MID, ep[15:8], 1'b1);
        rd(OFS_PRESSURE_RESULT_HIGH, ep[23:16], 1'b1);
        rd(OFS_TEMPERATURE_RESULT_LOW, et[7:0], 1'b1);
        rd(OFS_TEMPERATURE_RESULT_HIGH, et[15:8], 1'b1);
    endtask : rd_all
    // ==========================================================
    // monitor: read data lands one cycle after the strobe
    always @(posedge sys_clk) begin
        if (rd_seen) begin
            note = notes.pop_front();
            if (note[8]) begin
                cmp_byte(reg_rdata, note[7:0]);
            end
        end
        if (rstn) begin
            cmp_bit(fclr, fc_exp);
        end
        rd_seen <= reg_read === 1'b1;
        fc_exp  <= reg_read === 1'b1 && reg_addr == OFS_FILTER_STATE_CLEAR;
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        report_and_stop();
    end
    // ==========================================================
    // main sequence
    initial begin
        {sys_clk, rstn, hold, trig, sdone, rd_seen, fc_exp, rate, rawp, rawt} = '0;
        {err_total, cmp_count} = '0;
        seed = 32'h0000004B;
        repeat (20) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        rd(OFS_LOW_POWER_CONFIG, LOW_POWER_CONFIG_RESET, 1'b1);
        rd(OFS_SAMPLE_STATUS, 8'h00, 1'b1);
        rd(8'h40, 8'h00, 1'b1);
        rd(OFS_FILTER_STATE_CLEAR, 8'h00, 1'b0);
        // low current only changed in power-down, by read-modify-write
        rd(OFS_LOW_POWER_CONFIG, 8'h00, 1'b0);
        i_baro_host_model.wr(OFS_LOW_POWER_CONFIG, {6'h00, last_rd[1], 1'b1});
        cmp_bit(lcs, 1'b1);
        rd(OFS_LOW_POWER_CONFIG, 8'h01, 1'b1);
        x = rnd();
        off = x[15:0];
        i_baro_host_model.wr(OFS_PRESSURE_OFFSET_LOW, off[7:0]);
        i_baro_host_model.wr(OFS_PRESSURE_OFFSET_HIGH, off[15:8]);
        rate = 3'h1;
        @(posedge sys_clk);
        sample(p, t);
        rd(OFS_SAMPLE_STATUS, 8'h03, 1'b1);
        rd_all(p - {off, 8'h00}, t);
        rd(OFS_SAMPLE_STATUS, 8'h00, 1'b1);
        sample(p, t);
        sample(p, t);
        rd(OFS_SAMPLE_STATUS, 8'h33, 1'b1);
        rd_all(p - {off, 8'h00}, t);
        rd(OFS_SAMPLE_STATUS, 8'h00, 1'b1);
        // frozen results: a sample between byte reads must not mix in
        hold = 1'b1;
        sample(pa, ta);
        pa = pa - {off, 8'h00};
        rd(OFS_PRESSURE_RESULT_LOW, pa[7:0], 1'b1);
        sample(pb, tb);
        rd(OFS_PRESSURE_RESULT_MID, pa[15:8], 1'b1);
        rd(OFS_PRESSURE_RESULT_HIGH, pa[23:16], 1'b1);
        sample(p, t);
        rd_all(p - {off, 8'h00}, t);
        hold = 1'b0;
        rate = 3'h0;
        @(posedge sys_clk);
        sample(pb, tb);
        rd(OFS_SAMPLE_STATUS, 8'h00, 1'b1);
        rd_all(p - {off, 8'h00}, t);
        trig = 1'b1;
        @(posedge sys_clk);
        sample(p, t);
        cmp_bit(osc, 1'b1);
        trig = 1'b0;
        rd(OFS_SAMPLE_STATUS, 8'h03, 1'b1);
        rd_all(p - {off, 8'h00}, t);
        rd(OFS_FILTER_STATE_CLEAR, 8'h00, 1'b0);
        repeat (3) @(posedge sys_clk);
        report_and_stop();
    end
endmodule : baro_sensor_output_status_regs_bench
